// File: core/rcl_pkg.sv
/*
 * package for the regulator control block: register offsets, bit positions,
 * reset values and operating modes.
 * assumes one bus clock domain and a plain strobe register port.
 */
package rcl_pkg;

	localparam logic [7:0] RCL_CTRL_OFFSET  = 8'h00;
	localparam logic [7:0] RCL_MASK_OFFSET  = 8'h01;
	localparam int         RCL_FLAG_BIT     = 0;
	localparam int         RCL_IEN_BIT      = 1;
	localparam int         RCL_STAT_BIT     = 2;
	localparam logic       RCL_FLAG_RST     = 1'b0;
	localparam logic       RCL_IEN_RST      = 1'b0;
	localparam logic       RCL_STAT_RST     = 1'b0;
	localparam logic       RCL_MASK_RST     = 1'b1;
	localparam logic [7:0] RCL_RDATA_RST    = 8'h00;

	typedef enum logic [1:0] {
		RCL_MODE_SHUTDOWN,
		RCL_MODE_FULL,
		RCL_MODE_REDUCED
	} rcl_mode_e;

endpackage

// File: core/rcl_regulator_ctrl.sv
/*
 * digital control of the dual-output regulator: control/status register,
 * low-voltage detect status and flag, interrupt request and mode tracking.
 * assumes comparator and power-up inputs are synchronised here or are static.
 */
`timescale 1ns/1ps
// What this block does
// - bit 2 reads detect status; writes to it change nothing.
// - status is one only when supply low and in full performance mode.
// - bit 1 enables the request; request asserts while flag set, enabled and mask register bit 0 set.
// - bit 0 flag sets on every rising or falling change of status.
// - writing one clears the flag unless status changes in the same cycle; zero is ignored; nothing else clears it.
// - entering reduced power mode sets the flag if status was one, as status is forced low.
// - detector updates status only in full performance mode.
// - enable input low means shutdown; high means full or reduced mode.
// - power-on reset output high until core supply passes release level.
// - power-on reset stays active in every mode.
// - reduced power during stop mode, full performance otherwise, unless shutdown.
module rcl_regulator_ctrl
	import rcl_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       regulator_enable_input_i,
	input  wire logic       stop_mode_i,
	input  wire logic       supply_low_cmp_i,
	input  wire logic       core_supply_ok_i,
	output logic      [1:0] mode_o,
	output logic            power_on_reset_o,
	output logic            irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// mode tracking

	rcl_mode_e mode;
	// the enable input is static while powered, so it is used unsynchronised
	assign mode = !regulator_enable_input_i ? RCL_MODE_SHUTDOWN :
	              stop_mode_i               ? RCL_MODE_REDUCED  :
	                                          RCL_MODE_FULL;
	assign mode_o = mode;

	// power-on reset is a pure level, independent of mode
	assign power_on_reset_o = !core_supply_ok_i;

	////////////////////////////////////////////////////////////////////////////
	// detector synchroniser and status

	logic cmp_meta_ff;
	logic cmp_sync_ff;
	logic stat_ff;
	logic nxt_stat;
	logic stat_change;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cmp_meta_ff <= 1'b0;
			cmp_sync_ff <= 1'b0;
		end else begin
			cmp_meta_ff <= supply_low_cmp_i;
			cmp_sync_ff <= cmp_meta_ff;
		end
	end

	// outside full performance the detector is off and status forced low
	assign nxt_stat    = (mode == RCL_MODE_FULL) ? cmp_sync_ff : 1'b0;
	assign stat_change = nxt_stat != stat_ff;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			stat_ff <= RCL_STAT_RST;
		else
			stat_ff <= nxt_stat;
	end

	////////////////////////////////////////////////////////////////////////////
	// register file

	logic       flag_ff;
	logic       ien_ff;
	logic       mask_ff;
	logic       nxt_flag;
	logic       wr_ctrl;
	logic       wr_mask;
	logic       flag_clr;
	logic [7:0] rd_mux;

	assign wr_ctrl  = wr_i && (addr_i == RCL_CTRL_OFFSET);
	assign wr_mask  = wr_i && (addr_i == RCL_MASK_OFFSET);
	assign flag_clr = wr_ctrl && wdata_i[RCL_FLAG_BIT];
	// set wins over clear; a mode change sets the flag only through the status change it causes
	assign nxt_flag = stat_change ? 1'b1 : (flag_clr ? 1'b0 : flag_ff);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			flag_ff <= RCL_FLAG_RST;
			ien_ff  <= RCL_IEN_RST;
			mask_ff <= RCL_MASK_RST;
		end else begin
			flag_ff <= nxt_flag;
			if (wr_ctrl)
				ien_ff <= wdata_i[RCL_IEN_BIT];
			if (wr_mask)
				mask_ff <= wdata_i[RCL_FLAG_BIT];
		end
	end

	// status bit is read-only: no write path exists for it
	assign rd_mux = (addr_i == RCL_CTRL_OFFSET) ?
	                {5'h00, stat_ff, ien_ff, flag_ff} :
	                (addr_i == RCL_MASK_OFFSET) ? {7'h00, mask_ff} : 8'h00;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			rdata_o <= RCL_RDATA_RST;
		else
			rdata_o <= rd_i ? rd_mux : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt

	assign irq_o = flag_ff && ien_ff && mask_ff;

endmodule // rcl_regulator_ctrl

// File: sim/rcl_regulator_ctrl_checker.sv
/* port checks of rcl_regulator_ctrl; assumes one clock, async reset */
`timescale 1ns/1ps
module rcl_regulator_ctrl_checker
	import rcl_pkg::*;
(
	input wire logic       clk_i, reset_i, wr_i, rd_i, stop_mode_i, irq_o,
	input wire logic       regulator_enable_input_i, supply_low_cmp_i,
	input wire logic       core_supply_ok_i, power_on_reset_o,
	input wire logic [7:0] addr_i, wdata_i, rdata_o,
	input wire logic [1:0] mode_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire on = regulator_enable_input_i;
	sequence ctrl_rd; rd_i && addr_i == RCL_CTRL_OFFSET; endsequence
	por_level_a: assert property (power_on_reset_o == !core_supply_ok_i) else $error("por");
	shut_mode_a: assert property (!on |-> mode_o == RCL_MODE_SHUTDOWN) else $error("off");
	stop_mode_a: assert property (on && stop_mode_i |-> mode_o == RCL_MODE_REDUCED) else $error("rp");
	full_mode_a: assert property (on && !stop_mode_i |-> mode_o == RCL_MODE_FULL) else $error("fp");
	ien_off_a: assert property (wr_i && addr_i == RCL_CTRL_OFFSET && !wdata_i[RCL_IEN_BIT]
		|=> !irq_o) else $error("ien");
	flag_keep_a: assert property (irq_o && !wr_i |=> irq_o) else $error("kept");
	off_stat_a: assert property (ctrl_rd ##0 !on |=> !rdata_o[RCL_STAT_BIT]) else $error("st");
	high_zero_a: assert property (ctrl_rd |=> rdata_o[7:3] == 5'h00) else $error("hi");
	sync_lag_a: assert property ($rose(supply_low_cmp_i) && !irq_o && !wr_i |=> !irq_o)
		else $error("sync");
endmodule // rcl_regulator_ctrl_checker
bind rcl_regulator_ctrl rcl_regulator_ctrl_checker chk_inst (.*);

// File: sim/rcl_analog_model.sv
/* analog side: comparator and supply monitor; assumes levels from the bench */
`timescale 1ns/1ps
module rcl_analog_model (
	input  wire logic low_i, ok_i,
	output logic      cmp_o = 1'b0, ok_o = 1'b0
);
	// settles off the clock grid, so the design must synchronise it
	always @(low_i) cmp_o <= #37 low_i;
	always @(ok_i) ok_o <= #37 ok_i;
endmodule // rcl_analog_model

// File: sim/tb_rcl_regulator_ctrl.sv
/* bench of rcl_regulator_ctrl; assumes rcl_pkg and rcl_analog_model */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD %0t got %h want %h", $time, g, e); end end
module tb_rcl_regulator_ctrl;
	import rcl_pkg::*;
	logic       clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, en = 0, stop = 0, low = 1, ok = 0;
	logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
	logic [1:0] mode_o;
	logic       cmp, okd, por, irq;
	int         mismatches = 0, n_checks = 0, cyc = 0;
	always #50 clk_i = ~clk_i;
	rcl_analog_model rcl_analog_model_inst (.low_i(low), .ok_i(ok), .cmp_o(cmp), .ok_o(okd));
	rcl_regulator_ctrl rcl_regulator_ctrl_inst (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .regulator_enable_input_i(en), .stop_mode_i(stop),
		.supply_low_cmp_i(cmp), .core_supply_ok_i(okd), .mode_o, .power_on_reset_o(por),
		.irq_o(irq));
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i) begin addr_i <= a; wdata_i <= d; wr_i <= 1; end
		@(posedge clk_i) wr_i <= 0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge clk_i) begin addr_i <= a; rd_i <= 1; end
		@(posedge clk_i) rd_i <= 0;
		#1 `CHK(rdata_o, e)
	endtask
	task automatic end_sim;
		if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_i) if (++cyc == 900) begin mismatches++; end_sim; end
	initial begin
		repeat (10) @(posedge clk_i);
		reset_i <= 0;
		rd(8'h00, 8'h00);
		`CHK(mode_o, RCL_MODE_SHUTDOWN)
		`CHK(por, 1'b1)
		// enable level only moves under reset, as if powered anew
		@(posedge clk_i) begin reset_i <= 1; en <= 1; low <= 0; ok <= 1; end
		repeat (10) @(posedge clk_i);
		reset_i <= 0;
		`CHK(por, 1'b0)
		rd(8'h05, 8'h00);
		wr(8'h00, 8'hff);
		rd(8'h00, 8'h02);
		low <= 1;
		rd(8'h00, 8'h02);
		rd(8'h00, 8'h07);
		`CHK(irq, 1'b1)
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h05);
		wr(8'h00, 8'h03);
		stop <= 1;
		rd(8'h00, 8'h03);
		`CHK(mode_o, RCL_MODE_REDUCED)
		wr(8'h00, 8'h03);
		low <= 0;
		rd(8'h00, 8'h02);
		low <= 1;
		rd(8'h00, 8'h02);
		stop <= 0;
		rd(8'h00, 8'h07);
		rd(8'h00, 8'h07);
		end_sim;
	end
endmodule // tb_rcl_regulator_ctrl
